// [verilog/stc_pkg.sv]
`default_nettype none
// ============================================================
// Shared constants and types for the timer control block
package stc_pkg;
	// Register byte offsets
	localparam logic [3:0] STC_CTRL_OFS  = 4'h0;
	localparam logic [3:0] STC_COUNT_OFS = 4'h4;

	// Control field positions within the 16-bit control word
	localparam int STC_RUN_POS   = 15;
	localparam int STC_IDLE_POS  = 13;
	localparam int STC_GATE_POS  = 6;
	localparam int STC_PS_HI_POS = 5;
	localparam int STC_PS_LO_POS = 4;
	localparam int STC_SYNC_POS  = 2;
	localparam int STC_SRC_POS   = 1;

	// Reset values
	localparam logic [15:0] STC_CTRL_RST  = 16'h0000;
	localparam logic [15:0] STC_COUNT_RST = 16'h0000;

	// Prescale codes and terminal counts (divide ratio minus one)
	localparam logic [1:0] STC_PS_1   = 2'h0;
	localparam logic [1:0] STC_PS_8   = 2'h1;
	localparam logic [1:0] STC_PS_64  = 2'h2;
	localparam logic [1:0] STC_PS_256 = 2'h3;
	localparam logic [7:0] STC_TC_1   = 8'h00;
	localparam logic [7:0] STC_TC_8   = 8'h07;
	localparam logic [7:0] STC_TC_64  = 8'h3F;
	localparam logic [7:0] STC_TC_256 = 8'hFF;

	// Control register contents
	typedef struct packed {
		logic       timer_run_bit;
		logic       idle_stop_bit;
		logic       gated_accumulate_bit;
		logic [1:0] input_prescale_field;
		logic       ext_clock_sync_bit;
		logic       clock_source_bit;
	} stc_ctrl_t;

	// Wishbone request bundle
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  sel;
		logic [3:0]  adr;
		logic [31:0] dat;
	} stc_wb_req_t;
endpackage : stc_pkg
`default_nettype wire

// [verilog/stc_timer.sv]
`timescale 1ns/1ps
`default_nettype none
// Function
// - Timer counts while the run bit is one, unless idle mode is active with the idle stop bit one, and holds while it is zero.
// - Prescale field 11/10/01/00 divides the input clock by 256/64/8/1.
// - Gate bit ignored on external source; otherwise count only while gate is active.
// - External source: sync bit one synchronises the pin, zero samples it directly.
module stc_timer (
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	input  wire stc_pkg::stc_wb_req_t wb_req_i,
	output logic [31:0]              wb_dat_o,
	output logic                     wb_ack_o,
	input  wire logic                external_timer_clock_pin_i,
	input  wire logic                gate_i,
	input  wire logic                idle_mode_i,
	output logic [15:0]              count_o
);
	import stc_pkg::*;

	// ============================================================
	// State
	stc_ctrl_t   ctrl_q, ctrl_d;
	logic [15:0] count_q, count_d;
	logic [7:0]  pre_q, pre_d;
	logic        ack_q, ack_d;
	logic [31:0] rdat_q, rdat_d;
	logic        meta_q, sync_q, sync_prev_q, raw_prev_q;
	logic        meta_d, sync_d, sync_prev_d, raw_prev_d;

	logic        req;
	logic        wr_ctrl;
	logic        wr_count;
	logic        ext_rise;
	logic        src_tick;
	logic        running;
	logic [7:0]  term;
	logic        pre_tick;
	logic [15:0] ctrl_word;

	// ============================================================
	// External pin capture
	// Two-stage path for synchronised mode, single sample for direct mode
	// Direct mode relies on the pin already being synchronous to clk_i
	always_comb begin
		meta_d      = external_timer_clock_pin_i;
		sync_d      = meta_q;
		sync_prev_d = sync_q;
		raw_prev_d  = external_timer_clock_pin_i;
	end

	// Pin capture stages
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_q      <= 1'b0;
			sync_q      <= 1'b0;
			sync_prev_q <= 1'b0;
			raw_prev_q  <= 1'b0;
		end else begin
			meta_q      <= meta_d;
			sync_q      <= sync_d;
			sync_prev_q <= sync_prev_d;
			raw_prev_q  <= raw_prev_d;
		end
	end

	// Rising edge of the pin, through the chosen path
	always_comb begin
		if (ctrl_q.ext_clock_sync_bit) begin
			ext_rise = sync_q & ~sync_prev_q;
		end else begin
			ext_rise = external_timer_clock_pin_i & ~raw_prev_q;
		end
	end

	// ============================================================
	// Timer source, gating and prescaler
	always_comb begin
		if (ctrl_q.clock_source_bit) begin
			src_tick = ext_rise;
		end else if (ctrl_q.gated_accumulate_bit) begin
			src_tick = gate_i;
		end else begin
			src_tick = 1'b1;
		end
		running = ctrl_q.timer_run_bit & ~(idle_mode_i & ctrl_q.idle_stop_bit);
		case (ctrl_q.input_prescale_field)
			STC_PS_1:   term = STC_TC_1;
			STC_PS_8:   term = STC_TC_8;
			STC_PS_64:  term = STC_TC_64;
			STC_PS_256: term = STC_TC_256;
			default:    term = STC_TC_1;
		endcase
		pre_tick = running & src_tick & (pre_q >= term);
	end

	// ============================================================
	// Bus decode
	always_comb begin
		req      = wb_req_i.cyc & wb_req_i.stb & ~ack_q;
		wr_ctrl  = req & wb_req_i.we & (wb_req_i.adr == STC_CTRL_OFS);
		// Counter writes are refused while counting a synchronised external clock
		wr_count = req & wb_req_i.we & (wb_req_i.adr == STC_COUNT_OFS)
			& ~(ctrl_q.timer_run_bit & ctrl_q.clock_source_bit & ctrl_q.ext_clock_sync_bit);
		// Read-back image: unimplemented bits read zero
		ctrl_word = 16'h0000;
		ctrl_word[STC_RUN_POS]   = ctrl_q.timer_run_bit;
		ctrl_word[STC_IDLE_POS]  = ctrl_q.idle_stop_bit;
		ctrl_word[STC_GATE_POS]  = ctrl_q.gated_accumulate_bit;
		ctrl_word[STC_PS_HI_POS] = ctrl_q.input_prescale_field[1];
		ctrl_word[STC_PS_LO_POS] = ctrl_q.input_prescale_field[0];
		ctrl_word[STC_SYNC_POS]  = ctrl_q.ext_clock_sync_bit;
		ctrl_word[STC_SRC_POS]   = ctrl_q.clock_source_bit;
	end

	// ============================================================
	// Next-state computation
	// Control register, byte lanes honoured
	always_comb begin
		ctrl_d = ctrl_q;
		if (wr_ctrl) begin
			if (wb_req_i.sel[1]) begin
				ctrl_d.timer_run_bit = wb_req_i.dat[STC_RUN_POS];
				ctrl_d.idle_stop_bit = wb_req_i.dat[STC_IDLE_POS];
			end
			if (wb_req_i.sel[0]) begin
				ctrl_d.gated_accumulate_bit = wb_req_i.dat[STC_GATE_POS];
				ctrl_d.input_prescale_field = wb_req_i.dat[STC_PS_HI_POS:STC_PS_LO_POS];
				ctrl_d.ext_clock_sync_bit   = wb_req_i.dat[STC_SYNC_POS];
				ctrl_d.clock_source_bit     = wb_req_i.dat[STC_SRC_POS];
			end
		end
	end

	// Prescaler: restarts while the timer is stopped
	always_comb begin
		pre_d = pre_q;
		if (!running) begin
			pre_d = 8'h00;
		end else if (src_tick) begin
			pre_d = pre_tick ? 8'h00 : pre_q + 8'h01;
		end
	end

	// Counter: software write wins over an increment in the same cycle
	always_comb begin
		count_d = count_q;
		if (wr_count) begin
			if (wb_req_i.sel[1]) begin
				count_d[15:8] = wb_req_i.dat[15:8];
			end
			if (wb_req_i.sel[0]) begin
				count_d[7:0] = wb_req_i.dat[7:0];
			end
		end else if (pre_tick) begin
			count_d = count_q + 16'h0001;
		end
	end

	// Bus answer: ack one cycle after the request, read data latched
	always_comb begin
		ack_d  = req;
		rdat_d = rdat_q;
		// Unmapped addresses read zero
		if (req) begin
			case (wb_req_i.adr)
				STC_CTRL_OFS:  rdat_d = {16'h0000, ctrl_word};
				STC_COUNT_OFS: rdat_d = {16'h0000, count_q};
				default:       rdat_d = 32'h0000_0000;
			endcase
		end
	end

	// ============================================================
	// Registers
	// Control register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= stc_ctrl_t'(7'h00);
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	// Prescaler
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pre_q <= 8'h00;
		end else begin
			pre_q <= pre_d;
		end
	end

	// Counter
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_q <= STC_COUNT_RST;
		end else begin
			count_q <= count_d;
		end
	end

	// Bus answer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q  <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end else begin
			ack_q  <= ack_d;
			rdat_q <= rdat_d;
		end
	end

	// ============================================================
	// Outputs
	always_comb begin
		wb_dat_o = rdat_q;
		wb_ack_o = ack_q;
		count_o  = count_q;
	end
endmodule // stc_timer
`default_nettype wire

// [dv/stc_pin_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ====
// External clock pin source
module stc_pin_model (
	input  wire logic clk_i,
	output logic      pin_o
);
	initial pin_o = 1'b0;
	// Rising edges nine cycles apart
	task automatic pulses(input int n);
		repeat (n) begin
			@(posedge clk_i) pin_o <= 1'b1;
			repeat (4) @(posedge clk_i);
			pin_o <= 1'b0;
			repeat (4) @(posedge clk_i);
		end
	endtask
endmodule // stc_pin_model
`default_nettype wire

// [dv/stc_timer_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
// ====
// Timer control checker
module stc_timer_assertions (
	input wire logic                 clk_i,
	input wire logic                 rst_i,
	input wire stc_pkg::stc_wb_req_t wb_req_i,
	input wire logic                 wb_ack_o,
	input wire logic                 external_timer_clock_pin_i,
	input wire logic                 gate_i,
	input wire logic                 idle_mode_i,
	input wire logic [15:0]          count_o
);
	import stc_pkg::*;
	logic [15:0] c_q, c_d;
	logic        wr, w4;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Shadow of the control word
	assign wr = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & !wb_ack_o;
	assign w4 = wr & (wb_req_i.adr == STC_COUNT_OFS);
	assign c_d = (wr && wb_req_i.adr == STC_CTRL_OFS) ? wb_req_i.dat[15:0] : c_q;
	always_ff @(posedge clk_i) c_q <= rst_i ? 16'h0000 : c_d;
	sequence s_rise;
		c_q[15] && c_q[1] && c_q[5:4] == 2'h0 && $rose(external_timer_clock_pin_i);
	endsequence
	a_stop_holds: assert property (!c_q[15] && !w4 |=> $stable(count_o))
		else $error("count moved while stopped");
	a_run_counts: assert property (c_q[15] && !idle_mode_i && c_q[6:4] == 3'h0 && !c_q[1] && !w4
		|=> count_o == $past(count_o) + 16'h0001) else $error("count missed a tick");
	a_idle_stops: assert property (c_q[15] && c_q[13] && idle_mode_i && !w4 |=> $stable(count_o))
		else $error("count moved in idle");
	a_gate_blocks: assert property ((c_q[15] && !c_q[1] && c_q[6] && !gate_i && !w4) [*3] |=> $stable(count_o))
		else $error("count moved with gate low");
	a_div_eight: assert property (c_q[5:4] == 2'h1 && $changed(count_o) && !$past(w4) |=> $stable(count_o) [*7])
		else $error("divide by eight too fast");
	a_sync_delay: assert property ((s_rise and c_q[2]) |=> $stable(count_o) ##[1:3] $changed(count_o))
		else $error("synced edge timing wrong");
	a_direct_edge: assert property ((s_rise and !c_q[2]) |=> $changed(count_o))
		else $error("direct edge count late");
endmodule // stc_timer_assertions
bind stc_timer stc_timer_assertions chk_u (.clk_i, .rst_i, .wb_req_i, .wb_ack_o, .external_timer_clock_pin_i,
	.gate_i, .idle_mode_i, .count_o);
`default_nettype wire

// [dv/stc_timer_bench.sv]
`timescale 1ns/1ps
`default_nettype none
// ====
// Timer control bench
module stc_timer_bench;
	import stc_pkg::*;
	logic        clk_i, rst_i, gate, idle, pin, ack;
	logic [31:0] dat, rd;
	logic [15:0] cnt;
	stc_wb_req_t req;
	int          error_cnt, n_compared;
	stc_pin_model pin_u (.clk_i(clk_i), .pin_o(pin));
	stc_timer dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(dat), .wb_ack_o(ack),
		.external_timer_clock_pin_i(pin), .gate_i(gate), .idle_mode_i(idle), .count_o(cnt));
	task automatic stop_test;
		$display("compared %0d errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] e);
		n_compared++;
		if (rd !== e) begin
			error_cnt++;
			$display("[ERR] %0t got %h want %h", $time, rd, e);
		end
	endtask
	// One classic cycle, held until ack
	task automatic wb(input logic we, input logic [3:0] a, input logic [15:0] d);
		req <= '{1'b1, 1'b1, we, 4'hF, a, {16'h0000, d}};
		do @(posedge clk_i); while (ack !== 1'b1);
		rd = dat;
		req <= '0;
		@(posedge clk_i);
	endtask
	// Run from zero for k cycles or five pin edges, stop, read count
	task automatic run(input logic [15:0] c, input int k, input logic [31:0] e);
		wb(1'b1, STC_COUNT_OFS, 16'h0000);
		wb(1'b1, STC_CTRL_OFS, c);
		if (k > 0) repeat (k) @(posedge clk_i);
		else pin_u.pulses(5);
		wb(1'b1, STC_CTRL_OFS, 16'h0000);
		wb(1'b0, STC_COUNT_OFS, 16'h0000);
		chk(e);
		rd = {16'h0000, cnt};
		chk(e);
	endtask
	task automatic t_regs;
		wb(1'b0, STC_CTRL_OFS, 16'h0000);
		chk(32'h0000_0000);
		wb(1'b1, STC_CTRL_OFS, 16'h7FFF);
		wb(1'b0, STC_CTRL_OFS, 16'h0000);
		chk(32'h0000_2076);
		wb(1'b1, 4'h8, 16'hFFFF);
		wb(1'b0, 4'h8, 16'h0000);
		chk(32'h0000_0000);
		$display("regs done");
	endtask
	task automatic t_prescale;
		int sh[4] = '{0, 3, 6, 8};
		for (int p = 0; p < 4; p++) begin
			run({1'b1, 9'h000, 2'(p), 4'h0}, 508, 32'(511 >> sh[p]));
		end
		$display("prescale done");
	endtask
	task automatic t_modes;
		idle <= 1'b1;
		run(16'h8000, 8, 32'h0000_000B);
		run(16'hA000, 8, 32'h0000_0000);
		idle <= 1'b0;
		run(16'h8040, 8, 32'h0000_0000);
		gate <= 1'b1;
		run(16'h8040, 8, 32'h0000_000B);
		gate <= 1'b0;
		run(16'h8042, 0, 32'h0000_0005);
		run(16'h8046, 0, 32'h0000_0005);
		// Counter writes refused only while running a synchronised external clock
		wb(1'b1, STC_CTRL_OFS, 16'h8046);
		wb(1'b1, STC_COUNT_OFS, 16'h1234);
		wb(1'b1, STC_CTRL_OFS, 16'h0000);
		wb(1'b0, STC_COUNT_OFS, 16'h0000);
		chk(32'h0000_0005);
		wb(1'b1, STC_CTRL_OFS, 16'h8042);
		wb(1'b1, STC_COUNT_OFS, 16'h1234);
		wb(1'b1, STC_CTRL_OFS, 16'h0000);
		wb(1'b0, STC_COUNT_OFS, 16'h0000);
		chk(32'h0000_1234);
		$display("modes done");
	endtask
	// Clock and watchdog
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	initial begin
		#100us;
		error_cnt++;
		stop_test();
	end
	initial begin
		req = '0;
		gate = 1'b0;
		idle = 1'b0;
		rst_i = 1'b1;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_prescale();
		t_modes();
		stop_test();
	end
endmodule // stc_timer_bench
`default_nettype wire
